// file: pann_consts.svh
`ifndef PANN_CONSTS_SVH
`define PANN_CONSTS_SVH
// phy register indices of the window (5-bit phy register number)
`define PANN_IDX_EXPANSION 5'h06
`define PANN_IDX_NP_TX 5'h07
`define PANN_IDX_NP_RX 5'h08
`define PANN_IDX_MMD_SETUP 5'h0D
`define PANN_IDX_MMD_DATA 5'h0E
`define PANN_IDX_ADVERT 5'h04
// expansion status bits
`define PANN_EXP_PD_FAULT 4
`define PANN_EXP_LP_NP_ABLE 3
`define PANN_EXP_NP_ABLE 2
`define PANN_EXP_PAGE_RX 1
`define PANN_EXP_LP_AN_ABLE 0
// next page word bits
`define PANN_NP_NEXT 15
`define PANN_NP_ACK 14
`define PANN_NP_MSG 13
`define PANN_NP_ACK2 12
`define PANN_NP_TOGGLE 11
`define PANN_NP_FIELD_MSB 10
`define PANN_ADV_NP 15
// mmd setup fields
`define PANN_MMD_MODE_MSB 15
`define PANN_MMD_MODE_LSB 14
`define PANN_MMD_RSV_MSB 13
`define PANN_MMD_RSV_LSB 5
`define PANN_MMD_DEV_MSB 4
// reset values
`define PANN_NP_TX_RESET 16'h2001
`define PANN_SETUP_RESET 16'h0000
`define PANN_DATA_RESET 16'h0000
`define PANN_ZERO16 16'h0000
`define PANN_ONE16 16'h0001
`endif

// file: pann_pkg.sv
package pann_pkg;
    typedef enum logic [1:0] {
        PANN_MODE_ADDR = 2'b00,
        PANN_MODE_DATA = 2'b01,
        PANN_MODE_INC_RW = 2'b10,
        PANN_MODE_INC_WR = 2'b11
    } pann_mode_t;

    // register access from the management front end
    typedef struct packed {
        logic rdStb;
        logic wrStb;
        logic [4:0] idx;
        logic [15:0] wdata;
    } pann_req_t;

    // indirect access toward the selected mmd
    typedef struct packed {
        logic rdStb;
        logic wrStb;
        logic [4:0] dev;
        logic [15:0] addr;
        logic [15:0] wdata;
    } pann_mmd_req_t;

    // link partner information from the auto-negotiation engine
    typedef struct packed {
        logic pdFault;
        logic pageRx;
        logic [15:0] pageWord;
        logic lpNpAble;
        logic lpAnAble;
        logic txDone;
        logic txToggle;
    } pann_an_t;
endpackage

// file: pann_regs.sv
// Notes on behaviour
// RULE1: parallel detect fault latches high, bit 4
// RULE2: bit 3 shows partner next page ability
// RULE3: bit 2 always reads one
// RULE4: page received latches high, bit 1
// RULE5: bit 0 shows partner autoneg ability
// RULE6: tx word bits 15, 13 writable
// RULE7: tx word bit 12 writable, resets zero
// RULE8: tx toggle mirrors previous sent word
// RULE9: rx bit 14 shows successful receipt
// RULE10: rx bit 12 captures partner ack2
// RULE11: rx toggle has inverted sense
// RULE12: mode 00 data register holds address
// RULE13: mode 01 plain data, address kept
// RULE14: mode 10 increments on reads, writes
// RULE15: mode 11 increments on writes only
// RULE16: bits 4:0 select target mmd
// RULE17: data passes to mmd at held address
// RULE18: advertisement next page bit, writable
// RULE19: reading expansion clears latched bits
// RULE20: host sets address before data mode
module pann_regs
    import pann_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // management register access
    input wire pann_req_t req,
    output logic [15:0] rdata,
    output logic rdValid,
    // auto-negotiation engine, on core_clk
    input wire pann_an_t an,
    output logic [15:0] npTxWord,
    output logic advNextPage,
    // mmd side
    output pann_mmd_req_t mmdReq,
    input wire logic [15:0] mmdRdata
);
`include "pann_consts.svh"

    logic pdFault_reg;
    logic pageRx_reg;
    logic [15:0] npTx_reg;
    logic [15:0] npRx_reg;
    logic [15:0] setup_reg;
    logic [15:0] mmdAddr_reg;
    logic [15:0] dataWr_reg;
    logic advNp_reg;
    logic [15:0] rdata_next;
    logic wrExp;
    logic rdExp;
    logic wrTx;
    logic wrSetup;
    logic wrData;
    logic rdData;
    logic wrAdv;
    logic dataMode;
    logic incNow;
    pann_mode_t mode;

    assign mode = pann_mode_t'(setup_reg[`PANN_MMD_MODE_MSB:`PANN_MMD_MODE_LSB]);
    assign dataMode = (mode != PANN_MODE_ADDR);
    assign rdExp = req.rdStb && (req.idx == `PANN_IDX_EXPANSION);
    assign wrExp = req.wrStb && (req.idx == `PANN_IDX_EXPANSION);
    assign wrTx = req.wrStb && (req.idx == `PANN_IDX_NP_TX);
    assign wrSetup = req.wrStb && (req.idx == `PANN_IDX_MMD_SETUP);
    assign wrData = req.wrStb && (req.idx == `PANN_IDX_MMD_DATA);
    assign rdData = req.rdStb && (req.idx == `PANN_IDX_MMD_DATA);
    assign wrAdv = req.wrStb && (req.idx == `PANN_IDX_ADVERT);

    // a new event in the read cycle wins over the clear
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pdFault_reg <= 1'b0;
        end else if (an.pdFault) begin
            pdFault_reg <= 1'b1; // RULE1
        end else if (rdExp) begin
            pdFault_reg <= 1'b0; // RULE19
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pageRx_reg <= 1'b0;
        end else if (an.pageRx) begin
            pageRx_reg <= 1'b1; // RULE4
        end else if (rdExp) begin
            pageRx_reg <= 1'b0; // RULE19
        end
    end

    // local next page word; toggle is owned by the engine
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            npTx_reg <= `PANN_NP_TX_RESET;
        end else begin
            if (wrTx) begin
                npTx_reg[`PANN_NP_NEXT] <= req.wdata[`PANN_NP_NEXT]; // RULE6
                npTx_reg[`PANN_NP_MSG] <= req.wdata[`PANN_NP_MSG]; // RULE6
                npTx_reg[`PANN_NP_ACK2] <= req.wdata[`PANN_NP_ACK2]; // RULE7
                npTx_reg[`PANN_NP_FIELD_MSB:0] <= req.wdata[`PANN_NP_FIELD_MSB:0];
            end
            if (an.txDone) begin
                npTx_reg[`PANN_NP_TOGGLE] <= an.txToggle; // RULE8
            end
        end
    end

    // received page captured whole; the engine supplies inverted toggle sense
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            npRx_reg <= `PANN_ZERO16;
        end else if (an.pageRx) begin
            npRx_reg <= an.pageWord; // RULE9 RULE10 RULE11
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            advNp_reg <= 1'b0;
        end else if (wrAdv) begin
            advNp_reg <= req.wdata[`PANN_ADV_NP]; // RULE18
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            setup_reg <= `PANN_SETUP_RESET;
        end else if (wrSetup) begin
            setup_reg <= req.wdata; // RULE16
        end
    end

    // post increment applies after the access that uses the old address
    always_comb begin
        case (mode)
            PANN_MODE_INC_RW: incNow = wrData || rdData; // RULE14
            PANN_MODE_INC_WR: incNow = wrData; // RULE15
            PANN_MODE_DATA: incNow = 1'b0; // RULE13
            default: incNow = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mmdAddr_reg <= `PANN_ZERO16;
        end else if (wrData && !dataMode) begin
            mmdAddr_reg <= req.wdata; // RULE12
        end else if (incNow) begin
            mmdAddr_reg <= mmdAddr_reg + `PANN_ONE16;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dataWr_reg <= `PANN_DATA_RESET;
        end else if (wrData && dataMode) begin
            dataWr_reg <= req.wdata; // RULE17
        end
    end

    // mmd strobes are registered so address and data stand stable with them
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mmdReq <= '0;
        end else begin
            mmdReq.rdStb <= rdData && dataMode; // RULE17
            mmdReq.wrStb <= wrData && dataMode; // RULE17
            mmdReq.dev <= setup_reg[`PANN_MMD_DEV_MSB:0]; // RULE16
            mmdReq.addr <= mmdAddr_reg;
            mmdReq.wdata <= req.wdata;
        end
    end

    always_comb begin
        rdata_next = `PANN_ZERO16;
        case (req.idx)
            `PANN_IDX_EXPANSION: begin
                rdata_next[`PANN_EXP_PD_FAULT] = pdFault_reg || an.pdFault; // RULE1
                rdata_next[`PANN_EXP_LP_NP_ABLE] = an.lpNpAble; // RULE2
                rdata_next[`PANN_EXP_NP_ABLE] = 1'b1; // RULE3
                rdata_next[`PANN_EXP_PAGE_RX] = pageRx_reg || an.pageRx; // RULE4
                rdata_next[`PANN_EXP_LP_AN_ABLE] = an.lpAnAble; // RULE5
            end
            `PANN_IDX_NP_TX: rdata_next = npTx_reg;
            `PANN_IDX_NP_RX: rdata_next = npRx_reg;
            `PANN_IDX_ADVERT: rdata_next[`PANN_ADV_NP] = advNp_reg;
            `PANN_IDX_MMD_SETUP: rdata_next = setup_reg;
            `PANN_IDX_MMD_DATA: rdata_next = dataMode ? mmdRdata : mmdAddr_reg; // RULE12
            default: rdata_next = `PANN_ZERO16;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= `PANN_ZERO16;
            rdValid <= 1'b0;
        end else begin
            rdValid <= req.rdStb;
            if (req.rdStb) begin
                rdata <= rdata_next;
            end
        end
    end

    assign npTxWord = npTx_reg;
    assign advNextPage = advNp_reg;
endmodule

// file: pann_regs_sva.sv
module pann_regs_sva
    import pann_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register side
    input wire pann_req_t req,
    input wire logic [15:0] rdata,
    input wire logic rdValid,
    // engine and mmd side
    input wire pann_an_t an,
    input wire logic [15:0] npTxWord,
    input wire logic advNextPage,
    input wire pann_mmd_req_t mmdReq,
    input wire logic [15:0] mmdRdata
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire expRd = req.rdStb && req.idx == 5'h06;
    AST_RD_VALID: assert property (req.rdStb |=> rdValid) else $error("no read valid");
    AST_NO_VALID: assert property (!req.rdStb |=> !rdValid) else $error("stray valid");
    AST_NP_ABLE: assert property (expRd |=> rdata[2]) else $error("np able low");
    AST_PD_FAULT: assert property (expRd && an.pdFault |=> rdata[4]) else $error("fault lost");
    AST_PAGE_RX: assert property (expRd && an.pageRx |=> rdata[1]) else $error("page lost");
    AST_LP_ABLE: assert property (expRd |=> rdata[3] == $past(an.lpNpAble))
        else $error("partner np ability wrong");
    AST_TOGGLE: assert property (an.txDone |=> npTxWord[11] == $past(an.txToggle))
        else $error("toggle wrong");
    AST_NO_MMD: assert property (!req.wrStb |=> !mmdReq.wrStb)
        else $error("stray mmd write");
endmodule
bind pann_regs pann_regs_sva pann_regs_sva_inst (.core_clk(core_clk), .rst_n(rst_n),
    .req(req), .rdata(rdata), .rdValid(rdValid), .an(an), .npTxWord(npTxWord),
    .advNextPage(advNextPage), .mmdReq(mmdReq), .mmdRdata(mmdRdata));

// file: pann_mmd_model.sv
module pann_mmd_model
    import pann_pkg::*;
(
    // clock
    input wire logic core_clk,
    // mmd access
    input wire pann_mmd_req_t mmdReq,
    input wire logic [3:0] peekAddr,
    output logic [15:0] mmdRdata
);
    logic [15:0] mem [16];
    initial for (int i = 0; i < 16; i++) mem[i] = 16'hA500 + 16'(i);
    always @(posedge core_clk) if (mmdReq.wrStb) mem[mmdReq.addr[3:0]] <= mmdReq.wdata;
    // read data is combinational, bench points it at the held address
    assign mmdRdata = mem[peekAddr];
endmodule

// file: phy_autoneg_nextpage_mmd_regs_tb_top.sv
module phy_autoneg_nextpage_mmd_regs_tb_top
    import pann_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 0;
    logic rst_n = 0;
    pann_req_t req = '0;
    pann_an_t an = '0;
    logic [15:0] rdata, mmdRdata, npTxWord, rxW = '0, setW = '0, txW = 16'h2001, seed = 16'h003E;
    logic rdValid, advNextPage, pdM = 0, pgM = 0, tog = 0;
    pann_mmd_req_t mmdReq;
    logic [3:0] peekAddr = '0;
    int num_errors = 0, num_checks = 0, cyc = 0, mode = 0, dev = 0, addr = 0;
    int refMem [16];
    always #25 core_clk = ~core_clk;
    pann_regs pann_regs_inst (.core_clk(core_clk), .rst_n(rst_n), .req(req), .rdata(rdata),
        .rdValid(rdValid), .an(an), .npTxWord(npTxWord), .advNextPage(advNextPage),
        .mmdReq(mmdReq), .mmdRdata(mmdRdata));
    pann_mmd_model pann_mmd_model_inst (.core_clk(core_clk), .mmdReq(mmdReq),
        .peekAddr(peekAddr), .mmdRdata(mmdRdata));
    task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge core_clk) if (++cyc == 3000) begin
        num_errors++;
        complete_run();
    end
    function automatic logic [15:0] lfsr();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction
    task automatic acc(logic w, logic [4:0] idx, logic [15:0] d);
        @(posedge core_clk);
        req <= {!w, w, idx, d};
        peekAddr <= addr[3:0];
        @(posedge core_clk);
        req.rdStb <= 1'b0;
        req.wrStb <= 1'b0;
        #1;
    endtask
    task automatic wr(logic [4:0] idx, logic [15:0] d);
        acc(1, idx, d);
        if (idx == 5'h07) txW = d;
        if (idx == 5'h07) chk("txword", npTxWord, (d & 16'hB7FF) | {4'h0, tog, 11'h0});
        if (idx == 5'h0D) {mode, dev, setW} = {30'h0, d[15:14], 27'h0, d[4:0], d};
        if (idx == 5'h04) chk("adv", {15'h0, advNextPage}, {15'h0, d[15]});
        if (idx == 5'h0E && mode == 0) addr = d;
        if (idx == 5'h0E && mode != 0) begin
            chk("mmd", {mmdReq.wrStb, mmdReq.addr[9:0], mmdReq.dev}, {1'b1, 10'(addr), 5'(dev)});
            chk("mdata", mmdReq.wdata, d);
            refMem[addr] = d;
            if (mode >= 2) addr++;
        end
    endtask
    task automatic rd(logic [4:0] idx);
        logic [15:0] e;
        case (idx)
            5'h06: e = {11'h0, pdM, an.lpNpAble, 1'b1, pgM, an.lpAnAble};
            5'h07: e = (txW & 16'hB7FF) | {4'h0, tog, 11'h0};
            5'h08: e = rxW;
            5'h0D: e = setW;
            5'h0E: e = mode == 0 ? 16'(addr) : 16'(refMem[addr]);
            default: e = '0;
        endcase
        acc(0, idx, '0);
        chk("rdata", rdata, e);
        chk("rdvalid", {15'h0, rdValid}, 16'h0001);
        if (idx == 5'h06) {pdM, pgM} = 2'b00;
        if (idx == 5'h0E && mode == 2) addr++;
    endtask
    initial begin
        logic [15:0] s;
        for (int i = 0; i < 16; i++) refMem[i] = 16'hA500 + i;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        foreach (s[i]) if (i < 5) rd(i == 4 ? 5'h1F : 5'h06 + 5'(i));
        for (int k = 0; k < 4; k++) begin
            s = lfsr() | (k[0] ? 16'h0000 : 16'h001C);
            @(posedge core_clk);
            an <= {s[2], s[3], s, s[0], s[1], 1'b1, s[4]};
            @(posedge core_clk);
            {an.pdFault, an.pageRx, an.txDone} <= 3'b000;
            {pdM, pgM, tog} = {pdM | s[2], pgM | s[3], s[4]};
            if (s[3]) rxW = s;
            rd(5'h06);
            rd(5'h06);
            rd(5'h08);
            wr(5'h07, ~s);
            rd(5'h07);
            wr(5'h04, s);
            wr(5'h0D, {11'h0, s[4:0]});
            wr(5'h0E, 16'(k * 4));
            rd(5'h0E);
            wr(5'h0D, {k[1:0], 9'h0, s[4:0]});
            wr(5'h0E, s);
            wr(5'h0E, ~s);
            rd(5'h0E);
            rd(5'h0E);
            rd(5'h0D);
        end
        complete_run();
    end
endmodule
